/* File: svt_pkg.sv */
`default_nettype none
package svt_pkg;
  typedef logic [1:0] svt_sel_t;
endpackage
`default_nettype wire

/* File: svt_regs.svh */
`ifndef SVT_REGS_SVH
`define SVT_REGS_SVH
// timeout lengths in low-speed oscillator periods
`define SVT_PERIOD_00 32'd8192
`define SVT_PERIOD_01 32'd16384
`define SVT_PERIOD_10 32'd65536
`define SVT_PERIOD_11 32'd262144
// enable state after reset
`define SVT_ENABLE_RESET 1'b1
// period select after reset
`define SVT_SEL_RESET 2'h0
`endif

/* File: svt_supervision_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "svt_regs.svh"
module svt_supervision_timer
  import svt_pkg::*;
#(
  parameter int CNT_W = 18
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // low-speed oscillator tick and state
  input wire logic osc_tick,
  input wire logic osc_on,
  // software controls
  input wire logic sw_enable,
  input wire logic sw_disable,
  input wire logic sw_clear,
  input wire logic cal_done,
  input wire logic [1:0] period_sel,
  // status and reset request
  output logic enabled,
  output logic [CNT_W-1:0] count,
  output logic sys_reset_req
);

  // ****************************************
  // parameter checks
  // ****************************************
  if (CNT_W < 18) begin : g_cnt_too_narrow
    $error("CNT_W too small for longest timeout");
  end
  if (CNT_W > 32) begin : g_cnt_too_wide
    $error("CNT_W wider than the timeout compare");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic tick_s1_q;
  logic tick_s2_q;
  logic tick_s3_q;
  logic on_s1_q;
  logic on_s2_q;

  // edge detect reads only the second and third stages
  always_ff @(posedge clk) begin
    tick_s1_q <= osc_tick;
    tick_s2_q <= tick_s1_q;
    tick_s3_q <= tick_s2_q;
  end

  always_ff @(posedge clk) begin
    on_s1_q <= osc_on;
    on_s2_q <= on_s1_q;
  end

  // ****************************************
  // registers
  // ****************************************
  logic en_q;
  logic en_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic rst_req_q;
  svt_sel_t sel_q;

  // ****************************************
  // control decode
  // ****************************************
  logic [31:0] limit;
  logic [31:0] cnt_wide;
  wire tick_edge;
  wire osc_running;
  wire sel_chg;
  wire restart;
  wire advance;
  wire at_limit;
  wire expire;

  assign tick_edge = tick_s2_q & ~tick_s3_q;
  assign osc_running = on_s2_q;
  assign sel_chg = period_sel != sel_q;
  assign cnt_wide = 32'(cnt_q);

  assign limit = (period_sel == 2'h0) ? `SVT_PERIOD_00 :
                 (period_sel == 2'h1) ? `SVT_PERIOD_01 :
                 (period_sel == 2'h2) ? `SVT_PERIOD_10 : `SVT_PERIOD_11;

  // a new period select restarts the count so it never sits beyond the limit
  assign restart = sw_clear | sel_chg;
  assign advance = en_q & osc_running & tick_edge;
  assign at_limit = cnt_wide == limit - 32'd1;
  assign expire = advance & ~restart & at_limit;

  // calibration closes the timer; explicit enable reopens it
  assign en_d = (cal_done | sw_disable) ? 1'b0 :
                sw_enable ? 1'b1 : en_q;

  assign cnt_d = restart ? '0 :
                 expire ? '0 :
                 advance ? cnt_q + CNT_W'(1) : cnt_q;

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q <= `SVT_ENABLE_RESET;
    end else begin
      en_q <= en_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= expire;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_q <= `SVT_SEL_RESET;
    end else begin
      sel_q <= period_sel;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign enabled = en_q;
  assign count = cnt_q;
  assign sys_reset_req = rst_req_q;

  // ****************************************
  // checks
  // ****************************************
  a_enabled_after_reset: assert property (
    @(posedge clk) $rose(rst_n) |-> en_q)
  else begin
    $error("timer not enabled after reset");
  end

  a_counts_from_reset: assert property (
    @(posedge clk) $rose(rst_n) |-> cnt_q == '0 && !sys_reset_req)
  else begin
    $error("count not cleared by reset");
  end

  a_cal_disables: assert property (
    @(posedge clk) disable iff (!rst_n) cal_done |=> !en_q)
  else begin
    $error("calibration did not disable timer");
  end

  a_enable_reopens: assert property (
    @(posedge clk) disable iff (!rst_n) sw_enable && !cal_done && !sw_disable |=> en_q)
  else begin
    $error("enable did not reopen timer");
  end

  a_closed_no_reset: assert property (
    @(posedge clk) disable iff (!rst_n) !en_q |=> !sys_reset_req)
  else begin
    $error("reset request while timer closed");
  end

  a_osc_off_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    !osc_running && !restart |=> $stable(cnt_q) && !sys_reset_req)
  else begin
    $error("count moved while oscillator off");
  end

  a_idle_hold: assert property (
    @(posedge clk) disable iff (!rst_n) !advance && !restart |=> $stable(cnt_q))
  else begin
    $error("count moved without a tick");
  end

  a_limit_bound: assert property (
    @(posedge clk) disable iff (!rst_n) $stable(period_sel) |-> cnt_wide < limit)
  else begin
    $error("count beyond selected timeout");
  end

  a_count_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    advance && !restart && !at_limit |=> cnt_q == $past(cnt_q) + CNT_W'(1))
  else begin
    $error("tick did not advance count by one");
  end

  a_sel_restart: assert property (
    @(posedge clk) disable iff (!rst_n) sel_chg |=> cnt_q == '0 && !sys_reset_req)
  else begin
    $error("period change did not restart count");
  end

  a_expire_reset: assert property (
    @(posedge clk) disable iff (!rst_n) expire |=> sys_reset_req && cnt_q == '0)
  else begin
    $error("expiry without reset");
  end

  a_reset_cause: assert property (
    @(posedge clk) disable iff (!rst_n) sys_reset_req |-> $past(advance) && $past(at_limit))
  else begin
    $error("reset request without expiry");
  end

  a_reset_single: assert property (
    @(posedge clk) disable iff (!rst_n) sys_reset_req |=> !sys_reset_req)
  else begin
    $error("reset request longer than one cycle");
  end

  a_clear_zero: assert property (
    @(posedge clk) disable iff (!rst_n) sw_clear |=> cnt_q == '0 && !sys_reset_req)
  else begin
    $error("clear did not restart count");
  end

endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import svt_pkg::*;
  logic clk = 0, rst_n = 0, tk = 0, on = 1, en = 0, dis = 0, clr = 0, cal = 0;
  svt_sel_t sel = 2'h0;
  logic enabled, srr;
  logic [17:0] count;
  int err_count = 0, num_checks = 0, pulses = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (srr === 1'b1) pulses <= pulses + 1;
  svt_supervision_timer i_svt_supervision_timer (.clk(clk), .rst_n(rst_n), .osc_tick(tk),
    .osc_on(on), .sw_enable(en), .sw_disable(dis), .sw_clear(clr), .cal_done(cal),
    .period_sel(sel), .enabled(enabled), .count(count), .sys_reset_req(srr));
  task automatic chk(string n, logic [17:0] e, logic [17:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic ticks(int n);
    repeat (n) begin
      @(posedge clk) tk <= 1;
      @(posedge clk) tk <= 0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic ctl(logic [3:0] v);
    @(posedge clk) {cal, clr, dis, en} <= v;
    @(posedge clk) {cal, clr, dis, en} <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_run_stop;
    chk("enabled", 18'h1, enabled);
    ticks(5);
    chk("count", 18'h5, count);
    on <= 0;
    repeat (4) @(posedge clk);
    ticks(3);
    chk("count", 18'h5, count);
    on <= 1;
    repeat (4) @(posedge clk);
    ctl(4'h2);
    chk("enabled", 18'h0, enabled);
    ticks(2);
    chk("count", 18'h5, count);
    ctl(4'h3);
    chk("enabled", 18'h0, enabled);
    ctl(4'h1);
    chk("enabled", 18'h1, enabled);
    ticks(1);
    chk("count", 18'h6, count);
    ctl(4'h4);
    chk("count", 18'h0, count);
    $display("run stop clear done");
  endtask
  task automatic t_timeout;
    ticks(8191);
    chk("count", 18'h1fff, count);
    chk("pulses", 18'h0, pulses[17:0]);
    ticks(1);
    chk("pulses", 18'h1, pulses[17:0]);
    chk("count", 18'h0, count);
    ctl(4'h8);
    chk("enabled", 18'h0, enabled);
    ticks(2);
    chk("count", 18'h0, count);
    ctl(4'h9);
    chk("enabled", 18'h0, enabled);
    ctl(4'h1);
    ticks(1);
    chk("count", 18'h1, count);
    $display("timeout calibration done");
  endtask
  task automatic t_period_sel;
    sel <= 2'h1;
    repeat (2) @(posedge clk);
    chk("count", 18'h0, count);
    ticks(16383);
    chk("count", 18'h3fff, count);
    chk("pulses", 18'h1, pulses[17:0]);
    on <= 0;
    repeat (4) @(posedge clk);
    ticks(2);
    chk("pulses", 18'h1, pulses[17:0]);
    on <= 1;
    repeat (4) @(posedge clk);
    ticks(1);
    chk("pulses", 18'h2, pulses[17:0]);
    chk("count", 18'h0, count);
    sel <= 2'h2;
    ticks(8192);
    chk("count", 18'h2000, count);
    chk("pulses", 18'h2, pulses[17:0]);
    ticks(3);
    sel <= 2'h3;
    ticks(2);
    chk("count", 18'h2, count);
    chk("pulses", 18'h2, pulses[17:0]);
    $display("period select done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    t_run_stop;
    t_timeout;
    t_period_sel;
    tally_and_finish;
  end
endmodule
`default_nettype wire
